// file: common/fpci_map.svh
// Named constants for the floating-point coprocessor link.
`ifndef FPCI_MAP_SVH
`define FPCI_MAP_SVH

`define DATA_W 64
`define ID_W 5
`define REG_AW 5
`define NUM_FREGS 32
`define CNT_W 6

// Latency and repeat rate in floating-point cycles.
`define LAT_SIMPLE 6'd4
`define REP_SIMPLE 6'd1
`define LAT_DBL_MUL 6'd5
`define REP_DBL_MUL 6'd2
`define LAT_DIV_S 6'd17
`define REP_DIV_S 6'd14
`define LAT_DIV_D 6'd32
`define REP_DIV_D 6'd29
`define LAT_MOVE_IN 6'd42
`define REP_MOVE_IN 6'd1
`define LAT_MOVE_OUT 6'd1
`define REP_MOVE_OUT 6'd1

// Exponent field of a double-precision word.
`define EXP_MSB 62
`define EXP_LSB 52

// Last phase of the clock-ratio divider.
`define PHASE_LAST_FULL 2'h0
`define PHASE_LAST_HALF 2'h1
`define PHASE_LAST_TWO_THIRDS 2'h2

`endif

// file: common/fpci_pkg.sv
// Types shared by both ends of the floating-point coprocessor link.
`include "fpci_map.svh"
package fpci_pkg;
    typedef logic [`ID_W-1:0] instr_id_t;

    typedef enum logic [4:0] {
        op_add_s = 5'h00,
        op_sub_s = 5'h01,
        op_mul_s = 5'h02,
        op_fused_mul_add_s = 5'h03,
        op_fused_mul_sub_s = 5'h04,
        op_cmp = 5'h05,
        op_cvt = 5'h06,
        op_mov = 5'h07,
        op_mul_d = 5'h08,
        op_fused_mul_add_d = 5'h09,
        op_fused_mul_sub_d = 5'h0a,
        op_div_s = 5'h0b,
        op_sqrt_s = 5'h0c,
        op_div_d = 5'h0d,
        op_sqrt_d = 5'h0e,
        op_move_to_float = 5'h0f,
        op_load = 5'h10,
        op_move_from_float = 5'h11,
        op_store = 5'h12
    } op_t;

    typedef struct packed {
        op_t op;
        logic [`REG_AW-1:0] fd;
        logic [`REG_AW-1:0] fs;
        logic [`REG_AW-1:0] ft;
        instr_id_t id;
    } instr_t;

    typedef enum logic [1:0] {
        ratio_full = 2'h0,
        ratio_half = 2'h1,
        ratio_two_thirds = 2'h2
    } ratio_t;

    typedef enum logic [2:0] {
        st_fetch = 3'b001,
        st_wait_data = 3'b010,
        st_repeat = 3'b100
    } issue_state_t;

    typedef enum logic [1:0] {
        kind_reg = 2'h0,
        kind_store = 2'h1,
        kind_cc = 2'h2
    } kind_t;

    typedef struct packed {
        logic valid;
        kind_t kind;
        logic [`CNT_W-1:0] cnt;
        logic [`REG_AW-1:0] fd;
        instr_id_t id;
        logic [`DATA_W-1:0] res;
    } flight_t;
endpackage

// file: common/fpci_if.sv
// Link between the integer core end and the coprocessor end.
`timescale 1ns/1ps
`include "fpci_map.svh"
interface fpci_if;
    logic instr_valid;
    logic instr_ready;
    fpci_pkg::instr_t instr;
    logic ld_valid;
    logic ld_ready;
    logic [`DATA_W-1:0] ld_data;
    logic grad_valid;
    fpci_pkg::instr_id_t grad_id;
    logic st_valid;
    logic st_ready;
    logic [`DATA_W-1:0] st_data;
    logic cond_code;

    modport device(
        input instr_valid, instr, ld_valid, ld_data, grad_valid, grad_id, st_ready,
        output instr_ready, ld_ready, st_valid, st_data, cond_code
    );
    modport host(
        output instr_valid, instr, ld_valid, ld_data, grad_valid, grad_id, st_ready,
        input instr_ready, ld_ready, st_valid, st_data, cond_code
    );
endinterface

// file: design/two_entry_buffer.sv
// Two-entry queue with registered valid, ready and data outputs.
`timescale 1ns/1ps
module two_entry_buffer #(
    parameter int W = 64
) (
    // Clock and reset.
    input wire logic clock,
    input wire logic sys_rst,
    // Filling side.
    input wire logic in_valid,
    input wire logic [W-1:0] in_data,
    output logic in_ready,
    // Draining side.
    output logic out_valid,
    output logic [W-1:0] out_data,
    input wire logic out_ready
);
    logic [W-1:0] tail_r;
    logic tail_v_r;
    logic push;
    logic pop;

    assign in_ready = ~tail_v_r;
    assign push = in_valid & ~tail_v_r;
    assign pop = out_valid & out_ready;

    // The head always holds the older word, so nothing is overwritten while full.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            out_valid <= 1'b0;
            tail_v_r <= 1'b0;
            out_data <= '0;
            tail_r <= '0;
        end else if (pop || !out_valid) begin
            if (tail_v_r) begin
                out_data <= tail_r;
                out_valid <= 1'b1;
                tail_v_r <= push;
                tail_r <= in_data;
            end else begin
                out_valid <= push;
                out_data <= in_data;
            end
        end else if (push) begin
            tail_r <= in_data;
            tail_v_r <= 1'b1;
        end
    end
endmodule

// file: design/copro_interface_unit.sv
// Coprocessor end: interface queues, floating-point issue, timing and commit.
`timescale 1ns/1ps
`include "fpci_map.svh"
module copro_interface_unit #(
    parameter fpci_pkg::ratio_t CLOCK_RATIO = fpci_pkg::ratio_full,
    parameter int DEPTH = 4
) (
    // Clock and reset.
    input wire logic clock,
    input wire logic sys_rst,
    // Mode control.
    input wire logic flush_to_zero,
    // Link to the integer core.
    fpci_if.device link
);
    localparam int PW = $clog2(DEPTH);
    localparam int IW = $bits(fpci_pkg::instr_t);

    // Floating-point cycle enable derived from the core clock.
    logic [1:0] phase_r;
    logic [1:0] phase_last;
    logic fpu_en;

    assign phase_last = (CLOCK_RATIO == fpci_pkg::ratio_half) ? `PHASE_LAST_HALF :
                        (CLOCK_RATIO == fpci_pkg::ratio_two_thirds) ? `PHASE_LAST_TWO_THIRDS :
                        `PHASE_LAST_FULL;
    assign fpu_en = (CLOCK_RATIO == fpci_pkg::ratio_half) ? (phase_r == 2'h0) :
                    (phase_r != `PHASE_LAST_TWO_THIRDS);

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            phase_r <= 2'h0;
        end else begin
            phase_r <= (phase_r == phase_last) ? 2'h0 : phase_r + 2'h1;
        end
    end

    // Instruction and load data queues from the core, and the store data queue to it.
    logic iq_valid;
    logic iq_pop;
    logic [IW-1:0] iq_data;
    fpci_pkg::instr_t cur;
    logic ldq_valid;
    logic ldq_pop;
    logic [`DATA_W-1:0] ldq_data;
    logic st_push;
    logic st_room;
    logic [`DATA_W-1:0] st_push_data;

    two_entry_buffer #(.W(IW)) u_instr_queue (
        .clock(clock),
        .sys_rst(sys_rst),
        .in_valid(link.instr_valid),
        .in_data(link.instr),
        .in_ready(link.instr_ready),
        .out_valid(iq_valid),
        .out_data(iq_data),
        .out_ready(iq_pop)
    );

    two_entry_buffer #(.W(`DATA_W)) u_load_queue (
        .clock(clock),
        .sys_rst(sys_rst),
        .in_valid(link.ld_valid),
        .in_data(link.ld_data),
        .in_ready(link.ld_ready),
        .out_valid(ldq_valid),
        .out_data(ldq_data),
        .out_ready(ldq_pop)
    );

    two_entry_buffer #(.W(`DATA_W)) u_store_queue (
        .clock(clock),
        .sys_rst(sys_rst),
        .in_valid(st_push),
        .in_data(st_push_data),
        .in_ready(st_room),
        .out_valid(link.st_valid),
        .out_data(link.st_data),
        .out_ready(link.st_ready)
    );

    assign cur = fpci_pkg::instr_t'(iq_data);

    // Register file and in-flight table, oldest entry at the head.
    logic [`DATA_W-1:0] fregs_r [`NUM_FREGS];
    fpci_pkg::flight_t fl_r [DEPTH];
    logic [PW-1:0] head_r;
    logic [PW-1:0] tail_r;
    logic [PW:0] used_r;

    // Returns a stall flag above the operand; the youngest pending writer wins.
    function automatic logic [`DATA_W:0] read_operand(input logic [`REG_AW-1:0] r);
        logic [`DATA_W:0] v;
        logic [PW-1:0] k;
        v = {1'b0, fregs_r[r]};
        for (int i = 0; i < DEPTH; i++) begin
            k = head_r + PW'(i);
            if (fl_r[k].valid && fl_r[k].kind == fpci_pkg::kind_reg && fl_r[k].fd == r) begin
                v = {fl_r[k].cnt != '0, fl_r[k].res};
            end
        end
        return v;
    endfunction

    function automatic logic [2*`CNT_W-1:0] timing_of(input fpci_pkg::op_t op);
        case (op)
            fpci_pkg::op_mul_d, fpci_pkg::op_fused_mul_add_d, fpci_pkg::op_fused_mul_sub_d:
                timing_of = {`LAT_DBL_MUL, `REP_DBL_MUL};
            fpci_pkg::op_div_s, fpci_pkg::op_sqrt_s:
                timing_of = {`LAT_DIV_S, `REP_DIV_S};
            fpci_pkg::op_div_d, fpci_pkg::op_sqrt_d:
                timing_of = {`LAT_DIV_D, `REP_DIV_D};
            fpci_pkg::op_load, fpci_pkg::op_move_to_float:
                timing_of = {`LAT_MOVE_IN, `REP_MOVE_IN};
            fpci_pkg::op_store, fpci_pkg::op_move_from_float:
                timing_of = {`LAT_MOVE_OUT, `REP_MOVE_OUT};
            default:
                timing_of = {`LAT_SIMPLE, `REP_SIMPLE};
        endcase
    endfunction

    // Operand read, hazard check and decode of the instruction at the queue head.
    logic [`DATA_W:0] opa;
    logic [`DATA_W:0] opb;
    logic [`DATA_W:0] opc;
    logic uses_c;
    logic needs_ld;
    logic hazard;
    logic [`CNT_W-1:0] lat;
    logic [`CNT_W-1:0] rep;
    fpci_pkg::kind_t kind;

    assign opa = read_operand(cur.fs);
    assign opb = read_operand(cur.ft);
    assign opc = read_operand(cur.fd);
    assign uses_c = cur.op inside {fpci_pkg::op_fused_mul_add_s, fpci_pkg::op_fused_mul_sub_s,
                                   fpci_pkg::op_fused_mul_add_d, fpci_pkg::op_fused_mul_sub_d};
    assign needs_ld = cur.op inside {fpci_pkg::op_load, fpci_pkg::op_move_to_float};
    assign hazard = opa[`DATA_W] | opb[`DATA_W] | (uses_c & opc[`DATA_W]);
    assign {lat, rep} = timing_of(cur.op);
    assign kind = (cur.op inside {fpci_pkg::op_store, fpci_pkg::op_move_from_float}) ?
                  fpci_pkg::kind_store :
                  (cur.op == fpci_pkg::op_cmp) ? fpci_pkg::kind_cc : fpci_pkg::kind_reg;

    // Datapath stand-in: the product is truncated to a word before the add.
    logic [`DATA_W-1:0] prod;
    logic [`DATA_W-1:0] raw;
    logic [`DATA_W-1:0] res;
    logic arith;

    assign prod = opa[`DATA_W-1:0] * opb[`DATA_W-1:0];

    always_comb begin
        case (cur.op)
            fpci_pkg::op_add_s: raw = opa[`DATA_W-1:0] + opb[`DATA_W-1:0];
            fpci_pkg::op_sub_s: raw = opa[`DATA_W-1:0] - opb[`DATA_W-1:0];
            fpci_pkg::op_mul_s, fpci_pkg::op_mul_d: raw = prod;
            fpci_pkg::op_fused_mul_add_s, fpci_pkg::op_fused_mul_add_d:
                raw = prod + opc[`DATA_W-1:0];
            fpci_pkg::op_fused_mul_sub_s, fpci_pkg::op_fused_mul_sub_d:
                raw = prod - opc[`DATA_W-1:0];
            fpci_pkg::op_cmp:
                raw = {{(`DATA_W-1){1'b0}}, opa[`DATA_W-1:0] < opb[`DATA_W-1:0]};
            fpci_pkg::op_load, fpci_pkg::op_move_to_float: raw = ldq_data;
            default: raw = opa[`DATA_W-1:0];
        endcase
    end

    assign arith = (kind == fpci_pkg::kind_reg) && !needs_ld && (cur.op != fpci_pkg::op_mov);
    assign res = (arith && flush_to_zero && raw[`EXP_MSB:`EXP_LSB] == '0) ? '0 : raw;

    // Issue control; the float side never looks at core stalls.
    fpci_pkg::issue_state_t state_r;
    fpci_pkg::issue_state_t state_nxt;
    logic [`CNT_W-1:0] rep_cnt_r;
    logic can_issue;

    assign can_issue = (state_r == fpci_pkg::st_fetch) && fpu_en && iq_valid && !hazard &&
                       (used_r != (PW+1)'(DEPTH)) && (!needs_ld || ldq_valid);
    assign iq_pop = can_issue;
    assign ldq_pop = can_issue && needs_ld;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            fpci_pkg::st_fetch: begin
                if (iq_valid && needs_ld && !ldq_valid) begin
                    state_nxt = fpci_pkg::st_wait_data;
                end else if (can_issue && rep > `REP_SIMPLE) begin
                    state_nxt = fpci_pkg::st_repeat;
                end
            end
            fpci_pkg::st_wait_data: begin
                if (ldq_valid) begin
                    state_nxt = fpci_pkg::st_fetch;
                end
            end
            fpci_pkg::st_repeat: begin
                if (fpu_en && rep_cnt_r == `REP_SIMPLE) begin
                    state_nxt = fpci_pkg::st_fetch;
                end
            end
            default: state_nxt = fpci_pkg::st_fetch;
        endcase
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state_r <= fpci_pkg::st_fetch;
            rep_cnt_r <= '0;
        end else begin
            state_r <= state_nxt;
            if (can_issue) begin
                rep_cnt_r <= rep - `REP_SIMPLE;
            end else if (fpu_en && rep_cnt_r != '0) begin
                rep_cnt_r <= rep_cnt_r - `REP_SIMPLE;
            end
        end
    end

    // Graduation: ids below grad_next_r are cleared of speculation in the core.
    fpci_pkg::instr_id_t grad_next_r;
    fpci_pkg::instr_id_t grad_dist;
    fpci_pkg::flight_t hd;
    logic commit;
    logic cc_r;

    assign hd = fl_r[head_r];
    assign grad_dist = grad_next_r - hd.id;
    assign commit = fpu_en && hd.valid && hd.cnt == '0 && grad_dist != '0 &&
                    !grad_dist[`ID_W-1] && (hd.kind != fpci_pkg::kind_store || st_room);
    assign st_push = commit && hd.kind == fpci_pkg::kind_store;
    assign st_push_data = hd.res;
    assign link.cond_code = cc_r;

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            grad_next_r <= '0;
            cc_r <= 1'b0;
        end else begin
            if (link.grad_valid) begin
                grad_next_r <= link.grad_id + fpci_pkg::instr_id_t'(1);
            end
            if (commit && hd.kind == fpci_pkg::kind_cc) begin
                cc_r <= hd.res[0];
            end
        end
    end

    always_ff @(posedge clock) begin
        if (commit && hd.kind == fpci_pkg::kind_reg) begin
            fregs_r[hd.fd] <= hd.res;
        end
    end

    // In-flight table: count down latency, retire head in order, append at tail.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            head_r <= '0;
            tail_r <= '0;
            used_r <= '0;
            for (int i = 0; i < DEPTH; i++) begin
                fl_r[i] <= '0;
            end
        end else begin
            for (int i = 0; i < DEPTH; i++) begin
                if (fpu_en && fl_r[i].valid && fl_r[i].cnt != '0) begin
                    fl_r[i].cnt <= fl_r[i].cnt - `REP_SIMPLE;
                end
            end
            if (commit) begin
                fl_r[head_r].valid <= 1'b0;
                head_r <= head_r + PW'(1);
            end
            if (can_issue) begin
                fl_r[tail_r] <= '{valid: 1'b1, kind: kind, cnt: lat, fd: cur.fd, id: cur.id,
                                   res: res};
                tail_r <= tail_r + PW'(1);
            end
            used_r <= used_r + (PW+1)'(can_issue) - (PW+1)'(commit);
        end
    end
endmodule

// file: design/integer_core_end.sv
// Integer core end: tags instructions, feeds load data, graduates, takes store data.
`timescale 1ns/1ps
`include "fpci_map.svh"
module integer_core_end (
    // Clock and reset.
    input wire logic clock,
    input wire logic sys_rst,
    // Instructions from decode, in program order.
    input wire logic cmd_valid,
    input wire fpci_pkg::op_t cmd_op,
    input wire logic [`REG_AW-1:0] cmd_fd,
    input wire logic [`REG_AW-1:0] cmd_fs,
    input wire logic [`REG_AW-1:0] cmd_ft,
    output logic cmd_ready,
    // Load data from the address pipe.
    input wire logic ld_in_valid,
    input wire logic [`DATA_W-1:0] ld_in_data,
    output logic ld_in_ready,
    // Graduation of the oldest outstanding instruction.
    input wire logic grad_ok,
    // Store data back to the core.
    output logic st_out_valid,
    output logic [`DATA_W-1:0] st_out_data,
    input wire logic st_out_ready,
    // Condition code for branch resolution.
    output logic branch_cond,
    // Link to the coprocessor.
    fpci_if.host link
);
    localparam int IW = $bits(fpci_pkg::instr_t);

    fpci_pkg::instr_id_t id_r;
    fpci_pkg::instr_id_t gid_r;
    fpci_pkg::instr_t cmd_word;
    logic [IW-1:0] link_word;
    logic grad_valid_r;
    fpci_pkg::instr_id_t grad_id_r;
    logic outstanding;

    assign cmd_word = '{op: cmd_op, fd: cmd_fd, fs: cmd_fs, ft: cmd_ft, id: id_r};
    assign link.instr = fpci_pkg::instr_t'(link_word);
    assign outstanding = id_r != gid_r;
    assign link.grad_valid = grad_valid_r;
    assign link.grad_id = grad_id_r;

    two_entry_buffer #(.W(IW)) u_cmd_queue (
        .clock(clock),
        .sys_rst(sys_rst),
        .in_valid(cmd_valid),
        .in_data(cmd_word),
        .in_ready(cmd_ready),
        .out_valid(link.instr_valid),
        .out_data(link_word),
        .out_ready(link.instr_ready)
    );

    two_entry_buffer #(.W(`DATA_W)) u_load_feed (
        .clock(clock),
        .sys_rst(sys_rst),
        .in_valid(ld_in_valid),
        .in_data(ld_in_data),
        .in_ready(ld_in_ready),
        .out_valid(link.ld_valid),
        .out_data(link.ld_data),
        .out_ready(link.ld_ready)
    );

    two_entry_buffer #(.W(`DATA_W)) u_store_take (
        .clock(clock),
        .sys_rst(sys_rst),
        .in_valid(link.st_valid),
        .in_data(link.st_data),
        .in_ready(link.st_ready),
        .out_valid(st_out_valid),
        .out_data(st_out_data),
        .out_ready(st_out_ready)
    );

    // Graduation is given in id order, one instruction per pulse.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            id_r <= '0;
            gid_r <= '0;
            grad_valid_r <= 1'b0;
            grad_id_r <= '0;
            branch_cond <= 1'b0;
        end else begin
            if (cmd_valid && cmd_ready) begin
                id_r <= id_r + fpci_pkg::instr_id_t'(1);
            end
            grad_valid_r <= grad_ok && outstanding;
            if (grad_ok && outstanding) begin
                grad_id_r <= gid_r;
                gid_r <= gid_r + fpci_pkg::instr_id_t'(1);
            end
            branch_cond <= link.cond_code;
        end
    end
endmodule

// file: sim/fpci_link_monitor.sv
// Checker for the signals joining the two ends of the coprocessor link.
`timescale 1ns/1ps
module fpci_link_monitor (
    // Clock and reset.
    input wire logic clock,
    input wire logic sys_rst,
    // Link signals.
    input wire logic instr_valid,
    input wire logic instr_ready,
    input wire fpci_pkg::instr_t instr,
    input wire logic ld_valid,
    input wire logic ld_ready,
    input wire logic [63:0] ld_data,
    input wire logic grad_valid,
    input wire fpci_pkg::instr_id_t grad_id,
    input wire logic st_valid,
    input wire logic st_ready,
    input wire logic [63:0] st_data,
    input wire logic cond_code
);
    fpci_pkg::instr_id_t id_r;
    fpci_pkg::instr_id_t gid_r;
    logic [7:0] ngrad_r;
    logic [7:0] nst_r;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (sys_rst);
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            id_r <= '0;
            gid_r <= '0;
            ngrad_r <= 8'h00;
            nst_r <= 8'h00;
        end else begin
            id_r <= id_r + 5'(instr_valid && instr_ready);
            gid_r <= gid_r + 5'(grad_valid);
            ngrad_r <= ngrad_r + 8'(grad_valid);
            nst_r <= nst_r + 8'(st_valid && st_ready);
        end
    end
    AST_RESET_EMPTY: assert property ($fell(sys_rst) |-> !instr_valid && !ld_valid
        && !st_valid && instr_ready && ld_ready) else $error("queues not empty after reset");
    AST_INSTR_HOLD: assert property (instr_valid && !instr_ready
        |=> instr_valid && $stable(instr)) else $error("instruction lost while held off");
    AST_LD_HOLD: assert property (ld_valid && !ld_ready ##1 1'b1
        |-> ld_valid && ld_data == $past(ld_data)) else $error("load word lost");
    AST_ST_HOLD: assert property (st_valid && !st_ready |=> st_valid)
        else $error("store word dropped");
    AST_ST_DATA: assert property (st_valid && !st_ready |=> $stable(st_data))
        else $error("store word changed while held off");
    AST_ID_SEQ: assert property (instr_valid && instr_ready |-> instr.id == id_r)
        else $error("instruction id out of order");
    AST_GRAD_SEQ: assert property (grad_valid |-> grad_id == gid_r)
        else $error("graduation id out of order");
    AST_COMMIT_GRAD: assert property (st_valid |-> ngrad_r > nst_r)
        else $error("store committed before graduation");
    cover property (st_valid && !st_ready);
    cover property (grad_valid ##1 grad_valid);
    cover property ($rose(cond_code));
endmodule

// file: sim/testbench.sv
// Bench joining both ends of the coprocessor link.
`timescale 1ns/1ps
module testbench;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic flush_to_zero = 1'b0;
    logic cmd_valid = 1'b0;
    fpci_pkg::op_t cmd_op = fpci_pkg::op_add_s;
    logic [4:0] cmd_fd = 5'h00;
    logic [4:0] cmd_fs = 5'h00;
    logic [4:0] cmd_ft = 5'h00;
    logic ld_in_valid = 1'b0;
    logic [63:0] ld_in_data = 64'h0;
    logic grad_ok = 1'b0;
    logic st_out_ready = 1'b1;
    logic cmd_ready;
    logic ld_in_ready;
    logic st_out_valid;
    logic [63:0] st_out_data;
    logic branch_cond;
    int n_fail = 0;
    int checked = 0;
    logic [63:0] exp_q[$];
    always #25 clock = ~clock;
    fpci_if link();
    copro_interface_unit u_copro_interface_unit(.clock(clock), .sys_rst(sys_rst),
        .flush_to_zero(flush_to_zero), .link(link));
    integer_core_end u_integer_core_end(.clock(clock), .sys_rst(sys_rst),
        .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_fd(cmd_fd), .cmd_fs(cmd_fs),
        .cmd_ft(cmd_ft), .cmd_ready(cmd_ready), .ld_in_valid(ld_in_valid),
        .ld_in_data(ld_in_data), .ld_in_ready(ld_in_ready), .grad_ok(grad_ok),
        .st_out_valid(st_out_valid), .st_out_data(st_out_data),
        .st_out_ready(st_out_ready), .branch_cond(branch_cond), .link(link));
    fpci_link_monitor u_fpci_link_monitor(.clock(clock), .sys_rst(sys_rst),
        .instr_valid(link.instr_valid), .instr_ready(link.instr_ready), .instr(link.instr),
        .ld_valid(link.ld_valid), .ld_ready(link.ld_ready), .ld_data(link.ld_data),
        .grad_valid(link.grad_valid), .grad_id(link.grad_id), .st_valid(link.st_valid),
        .st_ready(link.st_ready), .st_data(link.st_data), .cond_code(link.cond_code));
    task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    // Issues one instruction; the graduation pulse follows in the next cycle when g is set.
    task automatic send(input fpci_pkg::op_t op, input logic [4:0] fd, fs, ft, input logic g);
        cmd_valid = 1'b1;
        cmd_op = op;
        cmd_fd = fd;
        cmd_fs = fs;
        cmd_ft = ft;
        while (cmd_ready !== 1'b1) begin
            @(posedge clock);
            #1;
        end
        @(posedge clock);
        #1;
        cmd_valid = 1'b0;
        grad_ok = g;
        idle(1);
        grad_ok = 1'b0;
    endtask
    task automatic move_in(input logic [4:0] fd, input logic [63:0] d);
        ld_in_valid = 1'b1;
        ld_in_data = d;
        while (ld_in_ready !== 1'b1) begin
            @(posedge clock);
            #1;
        end
        @(posedge clock);
        #1;
        ld_in_valid = 1'b0;
        send(fpci_pkg::op_move_to_float, fd, 5'h00, 5'h00, 1'b1);
    endtask
    task automatic store(input logic [4:0] fs, input logic [63:0] e, input logic g);
        exp_q.push_back(e);
        send(fpci_pkg::op_store, 5'h00, fs, fs, g);
    endtask
    // Sampled mid-cycle, where the handshake of the coming rising edge is already settled.
    always @(negedge clock) begin
        if (st_out_valid === 1'b1 && st_out_ready === 1'b1)
            chk("st_out_data", exp_q.size() > 0 ? exp_q.pop_front() : ~st_out_data, st_out_data);
    end
    initial begin
        #2000000;
        n_fail++;
        close_out();
    end
    initial begin
        fpci_pkg::op_t ops[6];
        logic [63:0] ev[6];
        ops = '{fpci_pkg::op_add_s, fpci_pkg::op_sub_s, fpci_pkg::op_mul_s,
            fpci_pkg::op_mul_d, fpci_pkg::op_div_s, fpci_pkg::op_sqrt_d};
        ev = '{64'hc, 64'h2, 64'h23, 64'h23, 64'h7, 64'h7};
        repeat (6) @(posedge clock);
        #1;
        sys_rst = 1'b0;
        chk("cmd_ready", 64'h1, 64'(cmd_ready));
        chk("st_out_valid", 64'h0, 64'(st_out_valid));
        chk("branch_cond", 64'h0, 64'(branch_cond));
        $display("test reset done");
        move_in(5'h01, 64'h5);
        move_in(5'h02, 64'h7);
        st_out_ready = 1'b0;
        for (int i = 0; i < 6; i++) begin
            send(ops[i], 5'(i + 3), 5'h02, 5'h01, 1'b1);
            store(5'(i + 3), ev[i], 1'b1);
        end
        idle(100);
        chk("st_out_valid stalled", 64'h1, 64'(st_out_valid));
        st_out_ready = 1'b1;
        idle(40);
        chk("stores drained", 64'h0, 64'(exp_q.size()));
        $display("test arithmetic done");
        store(5'h03, 64'hc, 1'b0);
        idle(80);
        chk("store held", 64'h1, 64'(exp_q.size()));
        grad_ok = 1'b1;
        idle(1);
        grad_ok = 1'b0;
        idle(20);
        chk("store released", 64'h0, 64'(exp_q.size()));
        $display("test graduation done");
        send(fpci_pkg::op_cmp, 5'h00, 5'h01, 5'h02, 1'b1);
        idle(20);
        chk("branch_cond", 64'h1, 64'(branch_cond));
        send(fpci_pkg::op_cmp, 5'h00, 5'h02, 5'h01, 1'b1);
        idle(20);
        chk("branch_cond", 64'h0, 64'(branch_cond));
        $display("test compare done");
        move_in(5'h09, 64'h1);
        idle(60);
        flush_to_zero = 1'b1;
        send(fpci_pkg::op_add_s, 5'h0a, 5'h09, 5'h09, 1'b1);
        store(5'h0a, 64'h0, 1'b1);
        idle(40);
        chk("flushed store", 64'h0, 64'(exp_q.size()));
        $display("test flush done");
        close_out();
    end
endmodule
